// ===== pkg/accel_ctrl_pkg.sv
package accel_ctrl_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_GIE       = 8'h04;
  localparam logic [7:0] OFF_IER_SET   = 8'h08;
  localparam logic [7:0] OFF_IER_CLR   = 8'h0C;
  localparam logic [7:0] OFF_ISR       = 8'h10;
  localparam logic [7:0] OFF_IN_DATA   = 8'h14;
  localparam logic [7:0] OFF_IN_CTRL   = 8'h18;
  localparam logic [7:0] OFF_OUT_DATA  = 8'h1C;
  localparam logic [7:0] OFF_OUT_CTRL  = 8'h20;

  // ****************************************
  // Register fields and reset values
  // ****************************************
  localparam int CTRL_GO       = 0;
  localparam int CTRL_FINISHED = 1;
  localparam int CTRL_QUIET    = 2;
  localparam int CTRL_ACCEPT   = 3;
  localparam int CTRL_RESUME   = 4;
  localparam int CTRL_AUTO     = 7;

  localparam int IN_VALID_BIT  = 0;
  localparam int IN_TAKEN_BIT  = 1;
  localparam int OUT_VALID_BIT = 0;
  localparam int OUT_TAKEN_BIT = 1;

  localparam int IRQ_SRC_FINISHED = 0;
  localparam int IRQ_SRC_ACCEPT   = 1;

  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [1:0]  IRQ_RESET  = 2'h0;

  // ****************************************
  // Core handshake bundles
  // ****************************************
  typedef struct packed {
    logic finished;
    logic quiescent;
    logic input_accept;
  } core_status_s;

  typedef struct packed {
    logic go;
    logic resume_permit;
  } core_cmd_s;

  typedef enum logic [1:0] {
    PROTO_NONE  = 2'b00,
    PROTO_VALID = 2'b01,
    PROTO_ACK   = 2'b10,
    PROTO_FULL  = 2'b11
  } param_proto_e;

endpackage

// ===== src/accel_ctrl_regs.sv
// The AHB-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module accel_ctrl_regs #(
  parameter int                            DATA_W     = 32,
  parameter logic                          HAS_GO     = 1'b1,
  parameter logic                          HAS_RESUME = 1'b1,
  parameter logic                          CHAINED    = 1'b0,
  parameter accel_ctrl_pkg::param_proto_e  IN_PROTO   = accel_ctrl_pkg::PROTO_FULL,
  parameter accel_ctrl_pkg::param_proto_e  OUT_PROTO  = accel_ctrl_pkg::PROTO_FULL
) (
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic      [31:0]                 hrdata,
  output logic                             hreadyout,
  output logic                             hresp,
  input  wire accel_ctrl_pkg::core_status_s core_status,
  output accel_ctrl_pkg::core_cmd_s        core_cmd,
  output logic      [DATA_W-1:0]           scalar_param_in,
  output logic                             param_valid_flag_in,
  input  wire logic                        param_taken_flag_in,
  input  wire logic [DATA_W-1:0]           scalar_param_out,
  input  wire logic                        param_valid_flag_out,
  output logic                             param_taken_flag_out,
  output logic                             irq
);
  import accel_ctrl_pkg::*;

  // ****************************************
  // Bus address phase capture
  // ****************************************
  logic        wr_pend;
  logic [7:0]  addr_q;

  wire       addr_take = hsel & hready & htrans[1];
  wire       wr_now    = wr_pend;
  wire       rd_take   = addr_take & ~hwrite;
  wire [7:0] rd_addr   = haddr[7:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      addr_q  <= 8'h00;
    end else begin
      wr_pend <= addr_take & hwrite;
      if (addr_take) begin
        addr_q <= haddr[7:0];
      end
    end
  end

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  wire wr_ctrl    = wr_now & hit(addr_q, OFF_CTRL);
  wire wr_gie     = wr_now & hit(addr_q, OFF_GIE);
  wire wr_ier_set = wr_now & hit(addr_q, OFF_IER_SET);
  wire wr_ier_clr = wr_now & hit(addr_q, OFF_IER_CLR);
  wire wr_isr     = wr_now & hit(addr_q, OFF_ISR);
  wire wr_in_data = wr_now & hit(addr_q, OFF_IN_DATA);
  wire wr_in_ctrl = wr_now & hit(addr_q, OFF_IN_CTRL);
  wire wr_out_ctl = wr_now & hit(addr_q, OFF_OUT_CTRL);

  // ****************************************
  // Core status, same clock, no synchroniser
  // ****************************************
  wire finished     = core_status.finished;
  wire quiescent    = core_status.quiescent;
  wire input_accept = core_status.input_accept;

  // ****************************************
  // Block control: go, resume, auto restart
  // ****************************************
  logic go;
  logic resume;
  logic auto_restart;

  wire sw_go      = wr_ctrl & hwdata[CTRL_GO];
  wire sw_resume  = wr_ctrl & hwdata[CTRL_RESUME];
  wire auto_go    = auto_restart & (CHAINED ? input_accept : finished);
  wire auto_res   = auto_restart & CHAINED & finished;
  wire go_drop    = ~auto_restart & (CHAINED ? input_accept : finished);
  wire next_go    = HAS_GO & (sw_go | auto_go | (go & ~go_drop));
  wire next_res   = HAS_RESUME & (sw_resume | auto_res);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      go           <= 1'b0;
      resume       <= 1'b0;
      auto_restart <= 1'b0;
    end else begin
      go     <= next_go;
      resume <= next_res;
      if (wr_ctrl) begin
        auto_restart <= hwdata[CTRL_AUTO];
      end
    end
  end

  // ****************************************
  // Scalar arguments
  // ****************************************
  logic [DATA_W-1:0] in_value;
  logic              in_valid;
  logic              out_taken;

  wire in_has_valid  = IN_PROTO[0];
  wire out_has_ack   = OUT_PROTO[1];
  wire next_in_valid = in_has_valid & wr_in_ctrl & hwdata[IN_VALID_BIT];
  wire next_out_tkn  = out_has_ack & wr_out_ctl & hwdata[OUT_TAKEN_BIT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_value  <= '0;
      in_valid  <= 1'b0;
      out_taken <= 1'b0;
    end else begin
      if (wr_in_data) begin
        in_value <= hwdata[DATA_W-1:0];
      end
      in_valid  <= next_in_valid;
      out_taken <= next_out_tkn;
    end
  end

  // ****************************************
  // Interrupt unit
  // ****************************************
  logic       gie;
  logic [1:0] ier;
  logic [1:0] isr;

  wire [1:0] src_event  = {input_accept, finished};
  wire [1:0] isr_toggle = wr_isr ? hwdata[1:0] : 2'b00;
  wire [1:0] next_ier   = (ier | (wr_ier_set ? hwdata[1:0] : 2'b00))
                          & ~(wr_ier_clr ? hwdata[1:0] : 2'b00);
  // Hardware set wins over a toggle in the same cycle
  wire [1:0] next_isr   = src_event | (isr ^ isr_toggle);
  wire       next_irq   = HAS_GO & gie & |(isr & ier);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gie <= 1'b0;
      ier <= IRQ_RESET;
      isr <= IRQ_RESET;
      irq <= 1'b0;
    end else begin
      if (wr_gie) begin
        gie <= HAS_GO & hwdata[0];
      end
      ier <= HAS_GO ? next_ier : IRQ_RESET;
      isr <= HAS_GO ? next_isr : IRQ_RESET;
      irq <= next_irq;
    end
  end

  // ****************************************
  // Read mux
  // ****************************************
  logic [31:0] rd_word;

  wire [31:0] ctrl_word = {24'h000000, auto_restart, 2'b00, resume,
                           input_accept, quiescent, finished, go};
  wire [31:0] out_ctrl  = {30'h00000000, out_taken, param_valid_flag_out};
  wire [31:0] in_ctrl   = {30'h00000000, param_taken_flag_in, in_valid};
  wire [31:0] out_data  = 32'(scalar_param_out);

  always_comb begin
    case (rd_addr)
      OFF_CTRL:     rd_word = ctrl_word;
      OFF_GIE:      rd_word = {31'h00000000, gie};
      OFF_IER_SET:  rd_word = {30'h00000000, ier};
      OFF_IER_CLR:  rd_word = {30'h00000000, ier};
      OFF_ISR:      rd_word = {30'h00000000, isr};
      OFF_IN_DATA:  rd_word = 32'(in_value);
      OFF_IN_CTRL:  rd_word = in_ctrl;
      OFF_OUT_DATA: rd_word = out_data;
      OFF_OUT_CTRL: rd_word = out_ctrl;
      default:      rd_word = RESET_WORD;
    endcase
  end

  // Sampled at the address edge; a read right behind a write sees the old value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= RESET_WORD;
    end else begin
      hrdata <= rd_take ? rd_word : RESET_WORD;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ****************************************
  // Core-facing outputs
  // ****************************************
  assign core_cmd               = {go, resume};
  assign scalar_param_in        = in_value;
  assign param_valid_flag_in    = in_valid;
  assign param_taken_flag_out   = out_taken;

  // ****************************************
  // Checks
  // ****************************************
  a_go_on_start: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_ctrl && hwdata[CTRL_GO] && HAS_GO) |=> core_cmd.go)
    else $error("go not raised after start write");

  a_auto_go: assert property (@(posedge hclk) disable iff (!hresetn)
    (auto_restart && !CHAINED && finished && HAS_GO) |=> core_cmd.go)
    else $error("auto restart did not raise go");

  a_chain_resume: assert property (@(posedge hclk) disable iff (!hresetn)
    (auto_restart && CHAINED && finished && HAS_RESUME) |=> core_cmd.resume_permit)
    else $error("chained resume missing");

  a_resume_cmd: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_ctrl && hwdata[CTRL_RESUME] && HAS_RESUME) |=> core_cmd.resume_permit)
    else $error("resume not raised");

  a_param_write: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_in_data |=> (scalar_param_in == $past(hwdata[DATA_W-1:0])))
    else $error("scalar input not written");

  a_ier_set: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_ier_set && !wr_ier_clr && HAS_GO) |=> ((ier & $past(hwdata[1:0])) == $past(hwdata[1:0])))
    else $error("enable set failed");

  a_ier_clr: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_ier_clr |=> ((ier & $past(hwdata[1:0])) == 2'b00))
    else $error("enable clear failed");

  a_isr_event: assert property (@(posedge hclk) disable iff (!hresetn)
    (finished && HAS_GO) |=> isr[IRQ_SRC_FINISHED])
    else $error("finished event not latched");

  a_irq_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    !gie |=> !irq)
    else $error("irq while globally disabled");

  a_irq_raise: assert property (@(posedge hclk) disable iff (!hresetn)
    (gie && |(isr & ier)) |=> irq)
    else $error("irq not raised");

  a_finished_read: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_take && rd_addr == OFF_CTRL) |=> hrdata[CTRL_FINISHED] == $past(finished))
    else $error("finished bit read wrong");

  a_quiet_read: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_take && rd_addr == OFF_CTRL) |=> hrdata[CTRL_QUIET] == $past(quiescent))
    else $error("quiescent bit read wrong");

  a_accept_read: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_take && rd_addr == OFF_CTRL) |=> hrdata[CTRL_ACCEPT] == $past(input_accept))
    else $error("accept bit read wrong");

  a_out_data_read: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_take && rd_addr == OFF_OUT_DATA) |=> hrdata == $past(out_data))
    else $error("scalar output read wrong");

  a_out_valid_read: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_take && rd_addr == OFF_OUT_CTRL) |=> hrdata[OUT_VALID_BIT] == $past(param_valid_flag_out))
    else $error("output valid read wrong");

  a_in_taken_read: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_take && rd_addr == OFF_IN_CTRL) |=> hrdata[IN_TAKEN_BIT] == $past(param_taken_flag_in))
    else $error("input taken read wrong");

  a_enable_read: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_take && rd_addr == OFF_IER_SET) |=> hrdata[1:0] == $past(ier))
    else $error("enable mask read wrong");

  a_status_read: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_take && rd_addr == OFF_ISR) |=> hrdata[1:0] == $past(isr))
    else $error("status mask read wrong");

  a_valid_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_in_ctrl && hwdata[IN_VALID_BIT] && in_has_valid) |=> param_valid_flag_in)
    else $error("input valid not raised");

  a_valid_drop: assert property (@(posedge hclk) disable iff (!hresetn)
    !wr_in_ctrl |=> !param_valid_flag_in)
    else $error("input valid longer than one cycle");

  a_taken_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_out_ctl && hwdata[OUT_TAKEN_BIT] && out_has_ack) |=> param_taken_flag_out)
    else $error("output taken not raised");

  a_taken_drop: assert property (@(posedge hclk) disable iff (!hresetn)
    !wr_out_ctl |=> !param_taken_flag_out)
    else $error("output taken longer than one cycle");

  a_resume_drop: assert property (@(posedge hclk) disable iff (!hresetn)
    (!sw_resume && !auto_res) |=> !core_cmd.resume_permit)
    else $error("resume without a cause");

  a_chain_go: assert property (@(posedge hclk) disable iff (!hresetn)
    (auto_restart && CHAINED && input_accept && HAS_GO) |=> core_cmd.go)
    else $error("chained restart did not raise go");

  a_go_drop: assert property (@(posedge hclk) disable iff (!hresetn)
    (!auto_restart && !CHAINED && finished && !sw_go) |=> !core_cmd.go)
    else $error("go held past finish");

  a_go_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (core_cmd.go && !finished && !input_accept) |=> core_cmd.go)
    else $error("go dropped early");

  a_gie_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_gie && HAS_GO) |=> gie == $past(hwdata[0]))
    else $error("global enable not written");

  a_accept_event: assert property (@(posedge hclk) disable iff (!hresetn)
    (input_accept && HAS_GO) |=> isr[IRQ_SRC_ACCEPT])
    else $error("accept event not latched");

  a_isr_toggle: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_isr && src_event == 2'b00 && HAS_GO) |=> isr == ($past(isr) ^ $past(hwdata[1:0])))
    else $error("status toggle failed");

  a_irq_drop: assert property (@(posedge hclk) disable iff (!hresetn)
    !(|(isr & ier)) |=> !irq)
    else $error("irq without enabled status");

  a_auto_write: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_ctrl |=> auto_restart == $past(hwdata[CTRL_AUTO]))
    else $error("auto restart not written");

  a_ier_keep: assert property (@(posedge hclk) disable iff (!hresetn)
    (!wr_ier_set && !wr_ier_clr) |=> $stable(ier))
    else $error("enables changed without write");

  a_param_keep: assert property (@(posedge hclk) disable iff (!hresetn)
    !wr_in_data |=> $stable(scalar_param_in))
    else $error("scalar input changed without write");

  a_gie_keep: assert property (@(posedge hclk) disable iff (!hresetn)
    !wr_gie |=> $stable(gie))
    else $error("global enable changed without write");

  a_gie_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_gie && !hwdata[0]) |=> !gie)
    else $error("global enable not cleared");

endmodule

// ===== bench/core_model.sv
`timescale 1ns/1ps
module core_model #(
  parameter int DATA_W = 32,
  parameter int LAT    = 6
) (
  input  wire logic                         hclk,
  input  wire logic                         hresetn,
  input  wire accel_ctrl_pkg::core_cmd_s    cmd,
  output accel_ctrl_pkg::core_status_s      status,
  input  wire logic [DATA_W-1:0]            param_in,
  input  wire logic                         valid_in,
  output logic                              taken_in,
  output logic      [DATA_W-1:0]            param_out,
  output logic                              valid_out,
  input  wire logic                         taken_out
);
  import accel_ctrl_pkg::*;
  // ****************************************
  // Busy counter started by go
  // ****************************************
  logic [3:0] cnt;
  logic       fin;
  logic       acc;
  wire        start_now = (cnt == 4'h0) && cmd.go && !fin;
  assign status    = {fin, (cnt == 4'h0) && !fin, acc};
  assign param_out = DATA_W'(param_in + 1);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt       <= 4'h0;
      fin       <= 1'b0;
      acc       <= 1'b0;
      taken_in  <= 1'b0;
      valid_out <= 1'b0;
    end else begin
      fin <= (cnt == 4'h1);
      acc <= start_now;
      if (cnt != 4'h0) cnt <= cnt - 4'h1;
      else if (start_now) cnt <= LAT[3:0];
      if (valid_in) taken_in <= 1'b1;
      if (taken_out) valid_out <= 1'b0;
      else if (fin) valid_out <= 1'b1;
    end
  end
endmodule

// ===== bench/test_accel_ctrl_regs.sv
`timescale 1ns/1ps
module test_accel_ctrl_regs;
  import accel_ctrl_pkg::*;
  logic         hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0]  haddr, hwdata, hrdata, scalar_param_in, scalar_param_out;
  logic [1:0]   htrans;
  logic         param_valid_flag_in, param_taken_flag_in;
  logic         param_valid_flag_out, param_taken_flag_out;
  core_status_s core_status;
  core_cmd_s    core_cmd;
  int           n_mismatch, compares, cyc;
  logic [31:0]  r;
  accel_ctrl_regs i_accel_ctrl_regs (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .core_status(core_status), .core_cmd(core_cmd), .scalar_param_in(scalar_param_in),
    .param_valid_flag_in(param_valid_flag_in), .param_taken_flag_in(param_taken_flag_in),
    .scalar_param_out(scalar_param_out), .param_valid_flag_out(param_valid_flag_out),
    .param_taken_flag_out(param_taken_flag_out), .irq(irq));
  core_model i_core_model (.hclk(hclk), .hresetn(hresetn), .cmd(core_cmd),
    .status(core_status), .param_in(scalar_param_in), .valid_in(param_valid_flag_in),
    .taken_in(param_taken_flag_in), .param_out(scalar_param_out),
    .valid_out(param_valid_flag_out), .taken_out(param_taken_flag_out));
  // ****************************************
  // Clock, bus and compare helpers
  // ****************************************
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    if (n_mismatch == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t word %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t flag %b expected %b", $time, g, e);
    end
  endtask
  task automatic count_go(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(negedge hclk);
      if (core_cmd.go === 1'b1) c++;
    end
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    logic [7:0] offs [5] = '{OFF_GIE, OFF_IER_SET, OFF_IER_CLR, OFF_ISR, 8'h40};
    bus(1'b0, OFF_CTRL, 32'h0);
    chk32(r, 32'h1 << CTRL_QUIET);
    foreach (offs[i]) begin
      bus(1'b0, offs[i], 32'h0);
      chk32(r, RESET_WORD);
    end
    chk1(irq, 1'b0);
  endtask
  task automatic t_start();
    int i;
    bus(1'b1, OFF_CTRL, 32'h1);
    @(negedge hclk);
    chk1(core_cmd.go, 1'b1);
    bus(1'b0, OFF_CTRL, 32'h0);
    chk32(r & 32'h5, 32'h1);
    i = 0;
    while (core_status.finished !== 1'b1 && i < 50) begin
      @(negedge hclk);
      i++;
    end
    chk1(i < 50, 1'b1);
    @(negedge hclk);
    chk1(core_cmd.go, 1'b0);
    bus(1'b0, OFF_CTRL, 32'h0);
    chk32(r & 32'hF, 32'h4);
  endtask
  task automatic t_irq();
    bus(1'b1, OFF_IER_SET, 32'h3);
    bus(1'b0, OFF_IER_SET, 32'h0);
    chk32(r, 32'h3);
    bus(1'b0, OFF_ISR, 32'h0);
    chk32(r, 32'h3);
    chk1(irq, 1'b0);
    bus(1'b1, OFF_GIE, 32'h1);
    bus(1'b0, OFF_GIE, 32'h0);
    chk32(r, 32'h1);
    chk1(irq, 1'b1);
    bus(1'b1, OFF_ISR, 32'h1);
    bus(1'b0, OFF_ISR, 32'h0);
    chk32(r, 32'h2);
    bus(1'b1, OFF_IER_CLR, 32'h2);
    bus(1'b0, OFF_IER_CLR, 32'h0);
    chk32(r, 32'h1);
    chk1(irq, 1'b0);
    bus(1'b1, OFF_ISR, 32'h1);
    bus(1'b1, OFF_GIE, 32'h0);
    bus(1'b0, OFF_ISR, 32'h0);
    chk32(r, 32'h3);
    chk1(irq, 1'b0);
  endtask
  task automatic t_auto();
    int c;
    bus(1'b1, OFF_CTRL, 32'h81);
    bus(1'b0, OFF_CTRL, 32'h0);
    chk1(r[CTRL_AUTO], 1'b1);
    count_go(60, c);
    chk1(c > 45, 1'b1);
    bus(1'b1, OFF_CTRL, 32'h0);
    repeat (20) @(negedge hclk);
    count_go(20, c);
    chk32(c, 32'h0);
  endtask
  task automatic t_resume();
    bus(1'b1, OFF_CTRL, 32'h10);
    @(negedge hclk);
    chk1(core_cmd.resume_permit, 1'b1);
    @(negedge hclk);
    chk1(core_cmd.resume_permit, 1'b0);
  endtask
  task automatic t_param();
    bus(1'b0, OFF_IN_CTRL, 32'h0);
    chk1(r[IN_TAKEN_BIT], 1'b0);
    bus(1'b1, OFF_IN_DATA, 32'hA5A5_0F0F);
    @(negedge hclk);
    chk32(scalar_param_in, 32'hA5A5_0F0F);
    bus(1'b0, OFF_OUT_DATA, 32'h0);
    chk32(r, 32'hA5A5_0F10);
    bus(1'b1, OFF_IN_CTRL, 32'h1);
    @(negedge hclk);
    chk1(param_valid_flag_in, 1'b1);
    bus(1'b0, OFF_IN_CTRL, 32'h0);
    chk1(r[IN_TAKEN_BIT], 1'b1);
    bus(1'b0, OFF_OUT_CTRL, 32'h0);
    chk1(r[OUT_VALID_BIT], 1'b1);
    bus(1'b1, OFF_OUT_CTRL, 32'h2);
    @(negedge hclk);
    chk1(param_taken_flag_out, 1'b1);
    bus(1'b0, OFF_OUT_CTRL, 32'h0);
    chk1(r[OUT_VALID_BIT], 1'b0);
  endtask
  initial begin
    n_mismatch = 0; compares = 0; cyc = 0;
    hresetn = 1'b0; hsel = 1'b0; hwrite = 1'b0; htrans = 2'h0;
    haddr = 32'h0; hwdata = 32'h0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_start();
    t_irq();
    t_auto();
    t_resume();
    t_param();
    wrap_up();
  end
endmodule
